// >>> design/wsm_top.sv
// Watchdog, supply level monitor and reset cause registers on the I/O register bus
`timescale 1ns/1ps
module wsm_top #(
	parameter int TICK_DIV = wsm_pkg::WSM_WDOG_TICK_DIV
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       dev_reset,
	input  wire logic [5:0] io_addr,
	input  wire logic [7:0] io_wdata,
	input  wire logic       io_we,
	input  wire logic       io_re,
	output logic      [7:0] io_rdata,
	input  wire logic       change_protect_we,
	input  wire logic [7:0] change_protect_wdata,
	input  wire logic       wdog_restart,
	input  wire logic       wdog_vector_ack,
	input  wire logic       wdog_always_on_fuse,
	input  wire logic       pin_reset_n,
	input  wire logic       supply_below_level,
	output logic            wdog_irq_req,
	output logic            wdog_reset_pulse,
	output logic            supply_low_irq,
	output logic            supply_por_req
);

	localparam int DIV_W = $clog2(TICK_DIV + 1);
	// Watchdog control state
	logic                     wdog_timeout_flag;
	logic                     wdog_irq_enable;
	logic                     wdog_reset_enable;
	logic [3:0]               wdog_period_select;
	// Supply monitor state
	logic                     supply_low_flag;
	logic                     supply_low_irq_enable;
	logic [2:0]               supply_trip_select;
	// Reset cause flags
	logic                     wdog_cause_flag;
	logic                     pin_reset_cause_flag;
	logic                     powerup_cause_flag;
	// Helpers
	logic [DIV_W-1:0]         div_count;
	logic                     osc_tick;
	logic [2:0]               window_count;
	logic                     window_open;
	logic                     wd_expire;
	logic                     wd_restart;
	logic                     wde_eff;
	logic                     fuse_programmed;
	wsm_pkg::wsm_mode_type    mode;
	logic                     pin_reset_sync_n;
	logic                     supply_low_sync;
	logic                     wr_wdog;
	logic                     wr_supply;
	logic                     wr_cause;
	logic                     next_flag_set;
	logic                     next_wdog_reset;
	logic                     supply_flag_prev;

	// Pins from outside the clock domain
	wsm_sync2 #(.WIDTH(1), .INIT_VAL(1'b1)) u_sync_pin (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in (pin_reset_n),
		.sync_out (pin_reset_sync_n)
	);
	wsm_sync2 #(.WIDTH(1), .INIT_VAL(1'b0)) u_sync_supply (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in (supply_below_level),
		.sync_out (supply_low_sync)
	);

	assign wr_wdog   = io_we && (io_addr == wsm_pkg::WSM_OFS_WDOG_CTRL_STATUS);
	assign wr_supply = io_we && (io_addr == wsm_pkg::WSM_OFS_SUPPLY_MONITOR);
	assign wr_cause  = io_we && (io_addr == wsm_pkg::WSM_OFS_RESET_CAUSE);

	// Oscillator tick divider; stands in for the separate watchdog oscillator
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_count <= '0;
		else if (osc_tick)
			div_count <= '0;
		else
			div_count <= div_count + DIV_W'(1);
	end
	assign osc_tick = (div_count == DIV_W'(TICK_DIV - 1));

	// Unlock window opened by the signature and closed once a watchdog write uses it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			window_count <= 3'h0;
		else if (change_protect_we && change_protect_wdata == wsm_pkg::WSM_CHANGE_SIGNATURE)
			window_count <= wsm_pkg::WSM_CHANGE_WINDOW;
		else if (wr_wdog || dev_reset)
			window_count <= 3'h0;
		else if (window_count != 3'h0)
			window_count <= window_count - 3'h1;
	end
	assign window_open = (window_count != 3'h0);

	// Mode decode; a programmed fuse reads 0 and pins the watchdog in reset mode
	assign fuse_programmed = !wdog_always_on_fuse;
	assign wde_eff = fuse_programmed || wdog_reset_enable || wdog_cause_flag;

	always_comb
	begin
		case ({fuse_programmed, wde_eff, wdog_irq_enable})
			3'b000:  mode = wsm_pkg::WSM_STOPPED;
			3'b001:  mode = wsm_pkg::WSM_IRQ_ONLY;
			3'b010:  mode = wsm_pkg::WSM_RESET_ONLY;
			3'b011:  mode = wsm_pkg::WSM_IRQ_THEN_RESET;
			default: mode = wsm_pkg::WSM_RESET_ONLY;
		endcase
	end

	// Counter is held while stopped, so enabling always starts a full period
	assign wd_restart = wdog_restart || dev_reset || (mode == wsm_pkg::WSM_STOPPED);

	wsm_wdog_counter u_counter (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.osc_tick    (osc_tick),
		.restart     (wd_restart),
		.period_code (wdog_period_select),
		.expire      (wd_expire)
	);

	// Expiry action per mode
	always_comb
	begin
		next_flag_set   = 1'b0;
		next_wdog_reset = 1'b0;
		if (wd_expire)
		begin
			case (mode)
				wsm_pkg::WSM_IRQ_ONLY:
					next_flag_set = 1'b1;
				wsm_pkg::WSM_RESET_ONLY:
					next_wdog_reset = 1'b1;
				wsm_pkg::WSM_IRQ_THEN_RESET:
				begin
					next_flag_set   = !wdog_timeout_flag;
					next_wdog_reset = wdog_timeout_flag;
				end
				default:
					next_flag_set = 1'b0;
			endcase
		end
	end

	// One clock reset pulse towards the reset controller
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog_reset_pulse <= 1'b0;
		else
			wdog_reset_pulse <= next_wdog_reset && !wdog_reset_pulse;
	end

	// Timeout flag: a new expiry wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog_timeout_flag <= 1'b0;
		else if (dev_reset)
			wdog_timeout_flag <= 1'b0;
		else if (next_flag_set)
			wdog_timeout_flag <= 1'b1;
		else if (wdog_vector_ack || (wr_wdog && io_wdata[wsm_pkg::WSM_WDOG_FLAG_BIT]))
			wdog_timeout_flag <= 1'b0;
	end

	// Interrupt enable; taking the vector in combined mode falls back to reset mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog_irq_enable <= 1'b0;
		else if (dev_reset)
			wdog_irq_enable <= 1'b0;
		else if (wr_wdog)
			wdog_irq_enable <= io_wdata[wsm_pkg::WSM_WDOG_IRQEN_BIT];
		else if (wdog_vector_ack && mode == wsm_pkg::WSM_IRQ_THEN_RESET)
			wdog_irq_enable <= 1'b0;
	end

	// Reset enable: set freely, cleared by device reset or by a write inside the window, both only with the cause flag clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog_reset_enable <= 1'b0;
		else if (wdog_cause_flag)
			wdog_reset_enable <= 1'b1;
		else if (dev_reset)
			wdog_reset_enable <= 1'b0;
		else if (wr_wdog && io_wdata[wsm_pkg::WSM_WDOG_RSTEN_BIT])
			wdog_reset_enable <= 1'b1;
		else if (wr_wdog && window_open)
			wdog_reset_enable <= 1'b0;
	end

	// Period select: free with the fuse unprogrammed, protected when programmed
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog_period_select <= wsm_pkg::WSM_PERIOD_RESET;
		else if (dev_reset)
			wdog_period_select <= wsm_pkg::WSM_PERIOD_RESET;
		else if (wr_wdog && (!fuse_programmed || window_open))
			wdog_period_select <= {io_wdata[wsm_pkg::WSM_WDOG_PER3_BIT], io_wdata[2:0]};
	end
	assign wdog_irq_req = wdog_timeout_flag && wdog_irq_enable;

	// Supply monitor control; reserved bits are not stored
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			supply_low_irq_enable <= 1'b0;
			supply_trip_select    <= wsm_pkg::WSM_TRIP_RESET;
		end
		else if (dev_reset)
		begin
			supply_low_irq_enable <= 1'b0;
			supply_trip_select    <= wsm_pkg::WSM_TRIP_RESET;
		end
		else if (wr_supply)
		begin
			supply_low_irq_enable <= io_wdata[wsm_pkg::WSM_SUPPLY_IRQEN_BIT];
			supply_trip_select    <= io_wdata[2:0];
		end
	end

	// Supply-low flag follows the comparator only in the flag selections
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			supply_low_flag  <= 1'b0;
			supply_flag_prev <= 1'b0;
		end
		else
		begin
			supply_low_flag  <= wsm_pkg::wsm_trip_is_flag(supply_trip_select)
				&& supply_low_sync && !dev_reset;
			supply_flag_prev <= supply_low_flag;
		end
	end

	// Interrupt pulse on each rising of the flag
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			supply_low_irq <= 1'b0;
		else
			supply_low_irq <= supply_low_flag && !supply_flag_prev && supply_low_irq_enable;
	end

	// Reset selections hold a power-on style request; not-allowed codes do nothing
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			supply_por_req <= 1'b0;
		else
			supply_por_req <= wsm_pkg::wsm_trip_is_por(supply_trip_select) && supply_low_sync;
	end

	// Cause flags survive device reset; only power-on clears them by hardware
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdog_cause_flag      <= wsm_pkg::WSM_CAUSE_POWERUP_VAL[wsm_pkg::WSM_CAUSE_WDOG_BIT];
			pin_reset_cause_flag <= wsm_pkg::WSM_CAUSE_POWERUP_VAL[wsm_pkg::WSM_CAUSE_PIN_BIT];
			powerup_cause_flag   <= wsm_pkg::WSM_CAUSE_POWERUP_VAL[wsm_pkg::WSM_CAUSE_PWR_BIT];
		end
		else
		begin
			if (wdog_reset_pulse)
				wdog_cause_flag <= 1'b1;
			else if (wr_cause)
				wdog_cause_flag <= io_wdata[wsm_pkg::WSM_CAUSE_WDOG_BIT];
			if (!pin_reset_sync_n)
				pin_reset_cause_flag <= 1'b1;
			else if (wr_cause)
				pin_reset_cause_flag <= io_wdata[wsm_pkg::WSM_CAUSE_PIN_BIT];
			if (wr_cause)
				powerup_cause_flag <= io_wdata[wsm_pkg::WSM_CAUSE_PWR_BIT];
		end
	end

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			io_rdata <= 8'h00;
		else if (io_re)
		begin
			case (io_addr)
				wsm_pkg::WSM_OFS_WDOG_CTRL_STATUS:
					io_rdata <= {wdog_timeout_flag, wdog_irq_enable, wdog_period_select[3],
						1'b0, wde_eff, wdog_period_select[2:0]};
				wsm_pkg::WSM_OFS_SUPPLY_MONITOR:
					io_rdata <= {supply_low_flag, supply_low_irq_enable, 3'h0,
						supply_trip_select};
				wsm_pkg::WSM_OFS_RESET_CAUSE:
					io_rdata <= {4'h0, wdog_cause_flag, 1'b0, pin_reset_cause_flag,
						powerup_cause_flag};
				default:
					io_rdata <= 8'h00;
			endcase
		end
	end

	AST_IRQ_MODE_SETS_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wd_expire && mode == wsm_pkg::WSM_IRQ_ONLY && !dev_reset) |=> wdog_timeout_flag)
		else $error("expiry in interrupt mode did not set the flag");
	AST_VECTOR_CLEARS_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wdog_vector_ack && !next_flag_set) |=> !wdog_timeout_flag)
		else $error("vector taken but flag still set");
	AST_IRQ_MODE_NO_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wd_expire && mode == wsm_pkg::WSM_IRQ_ONLY) |=> !wdog_reset_pulse)
		else $error("interrupt mode expiry produced a reset");
	AST_COMBINED_ACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wdog_vector_ack && !wr_wdog && !next_flag_set
		&& mode == wsm_pkg::WSM_IRQ_THEN_RESET) |=> (!wdog_irq_enable && !wdog_timeout_flag))
		else $error("combined mode vector did not drop enable and flag");
	AST_SECOND_EXPIRY_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wd_expire && mode == wsm_pkg::WSM_IRQ_THEN_RESET && wdog_timeout_flag
		&& !wdog_reset_pulse) |=> wdog_reset_pulse ##1 wdog_cause_flag)
		else $error("second expiry did not reset");
	AST_FUSE_ALWAYS_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wd_expire && !wdog_always_on_fuse && !wdog_reset_pulse) |=> wdog_reset_pulse)
		else $error("programmed fuse expiry did not reset");
	AST_WDOG_BIT4_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(io_re && io_addr == wsm_pkg::WSM_OFS_WDOG_CTRL_STATUS) |=> !io_rdata[4])
		else $error("watchdog reserved bit read as one");
	AST_CAUSE_FORCES_WDE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wdog_cause_flag |=> wdog_reset_enable)
		else $error("reset enable not forced by cause flag");
	AST_WINDOW_GUARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wdog_reset_enable && !window_open && !dev_reset) |=> wdog_reset_enable)
		else $error("reset enable cleared outside the unlock window");
	AST_CAUSE_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(io_re && io_addr == wsm_pkg::WSM_OFS_RESET_CAUSE) |=> (io_rdata[7:4] == 4'h0 && !io_rdata[2]))
		else $error("reset cause reserved bits read nonzero");
	AST_RESET_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wdog_reset_pulse |=> !wdog_reset_pulse)
		else $error("watchdog reset pulse longer than one clock");

endmodule

// >>> design/wsm_pkg.sv
// Shared constants, types and decode helpers for the watchdog and supply monitor block
package wsm_pkg;

	// Register offsets in the I/O space
	localparam logic [5:0] WSM_OFS_WDOG_CTRL_STATUS = 6'h31;
	localparam logic [5:0] WSM_OFS_SUPPLY_MONITOR   = 6'h34;
	localparam logic [5:0] WSM_OFS_RESET_CAUSE      = 6'h3B;

	// Watchdog control/status field positions
	localparam int WSM_WDOG_FLAG_BIT  = 7;
	localparam int WSM_WDOG_IRQEN_BIT = 6;
	localparam int WSM_WDOG_PER3_BIT  = 5;
	localparam int WSM_WDOG_RSV_BIT   = 4;
	localparam int WSM_WDOG_RSTEN_BIT = 3;

	// Supply monitor field positions
	localparam int WSM_SUPPLY_FLAG_BIT  = 7;
	localparam int WSM_SUPPLY_IRQEN_BIT = 6;

	// Reset cause field positions
	localparam int WSM_CAUSE_WDOG_BIT = 3;
	localparam int WSM_CAUSE_PIN_BIT  = 1;
	localparam int WSM_CAUSE_PWR_BIT  = 0;

	// Values after reset
	localparam logic [3:0] WSM_PERIOD_RESET      = 4'h0;
	localparam logic [2:0] WSM_TRIP_RESET        = 3'h0;
	localparam logic [7:0] WSM_CAUSE_POWERUP_VAL = 8'h01;

	// Protected change unlock
	localparam logic [7:0] WSM_CHANGE_SIGNATURE = 8'hD8;
	localparam logic [2:0] WSM_CHANGE_WINDOW    = 3'h4;

	// Watchdog oscillator emulated by a divider on the system clock
	localparam int WSM_SYS_CLK_HZ   = 100000000;
	localparam int WSM_WDOG_OSC_HZ  = 128000;
	localparam int WSM_WDOG_TICK_DIV = WSM_SYS_CLK_HZ / WSM_WDOG_OSC_HZ;

	// Watchdog period table
	localparam int         WSM_PERIOD_CNT_W    = 20;
	localparam int         WSM_PERIOD_BASE     = 2048;
	localparam logic [3:0] WSM_PERIOD_CODE_MAX = 4'h9;

	// Supply trip selections
	localparam logic [2:0] WSM_TRIP_OFF     = 3'h0;
	localparam logic [2:0] WSM_TRIP_POR_LO  = 3'h1;
	localparam logic [2:0] WSM_TRIP_POR_HI  = 3'h2;
	localparam logic [2:0] WSM_TRIP_FLAG_LO = 3'h3;
	localparam logic [2:0] WSM_TRIP_FLAG_HI = 3'h4;

	// Watchdog operating modes
	typedef enum logic [1:0] {
		WSM_STOPPED,
		WSM_IRQ_ONLY,
		WSM_RESET_ONLY,
		WSM_IRQ_THEN_RESET
	} wsm_mode_type;

	// Last count of a period; reserved codes fall back to the longest period
	function automatic logic [19:0] wsm_period_last(input logic [3:0] code);
		logic [3:0]  c;
		logic [20:0] span;
		c = (code > WSM_PERIOD_CODE_MAX) ? WSM_PERIOD_CODE_MAX : code;
		span = 21'(WSM_PERIOD_BASE) << c;
		return 20'(span - 21'h000001);
	endfunction

	// Trip selections that raise a power-on style reset
	function automatic logic wsm_trip_is_por(input logic [2:0] sel);
		return (sel == WSM_TRIP_POR_LO) || (sel == WSM_TRIP_POR_HI);
	endfunction

	// Trip selections that set the supply-low flag
	function automatic logic wsm_trip_is_flag(input logic [2:0] sel);
		return (sel == WSM_TRIP_FLAG_LO) || (sel == WSM_TRIP_FLAG_HI);
	endfunction

endpackage

// >>> design/wsm_sync2.sv
// Two flip-flop level synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
module wsm_sync2 #(
	parameter int          WIDTH    = 1,
	parameter logic [0:0]  INIT_VAL = 1'b0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second one
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage_one <= {WIDTH{INIT_VAL}};
			sync_out  <= {WIDTH{INIT_VAL}};
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule

// >>> design/wsm_wdog_counter.sv
// Watchdog period counter running on the watchdog oscillator tick enable
`timescale 1ns/1ps
module wsm_wdog_counter (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       osc_tick,
	input  wire logic       restart,
	input  wire logic [3:0] period_code,
	output logic            expire
);

	logic [wsm_pkg::WSM_PERIOD_CNT_W-1:0] count;
	logic                                 at_last;

	assign at_last = (count >= wsm_pkg::wsm_period_last(period_code));

	// Count oscillator ticks; a shortened period after a change expires at once
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count  <= '0;
			expire <= 1'b0;
		end
		else if (restart)
		begin
			count  <= '0;
			expire <= 1'b0;
		end
		else if (osc_tick)
		begin
			count  <= at_last ? '0 : count + 20'h00001;
			expire <= at_last;
		end
		else
		begin
			expire <= 1'b0;
		end
	end

endmodule

// >>> test/wsm_core_model.sv
// Processor core model driving the I/O register bus and the core strobes
`timescale 1ns/1ps
module wsm_core_model (
	input  wire logic       clk_sys,
	output logic      [5:0] io_addr,
	output logic      [7:0] io_wdata,
	output logic            io_we,
	output logic            io_re,
	input  wire logic [7:0] io_rdata,
	output logic            change_protect_we,
	output logic      [7:0] change_protect_wdata,
	output logic            wdog_restart,
	output logic            wdog_vector_ack
);
	// Idle bus from time zero
	initial
	begin
		io_addr = 6'h00;
		io_wdata = 8'h00;
		io_we = 1'b0;
		io_re = 1'b0;
		change_protect_we = 1'b0;
		change_protect_wdata = 8'h00;
		wdog_restart = 1'b0;
		wdog_vector_ack = 1'b0;
	end

	// One write; released lines show the inverse so stale values never pass
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 6'h34)
			v[5:3] = 3'h0;
		if (a == 6'h31 && v[5] && v[2:1] != 2'h0)
			v[2:1] = 2'h0;
		@(posedge clk_sys);
		io_addr <= a;
		io_wdata <= v;
		io_we <= 1'b1;
		@(posedge clk_sys);
		io_we <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~v;
		#1;
	endtask

	// One read; data is registered on the same edge that takes the strobe
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		io_addr <= a;
		io_re <= 1'b1;
		@(posedge clk_sys);
		io_re <= 1'b0;
		io_addr <= ~a;
		#1;
		d = io_rdata;
	endtask

	// Signature write; the watchdog write must follow within four cycles
	task automatic unlock();
		@(posedge clk_sys);
		change_protect_we <= 1'b1;
		change_protect_wdata <= 8'hD8;
		@(posedge clk_sys);
		change_protect_we <= 1'b0;
		change_protect_wdata <= 8'h27;
	endtask

	// One-cycle strobe: vector taken when ack is set, else restart instruction
	task automatic strobe(input bit ack);
		@(posedge clk_sys);
		wdog_vector_ack <= ack;
		wdog_restart <= !ack;
		@(posedge clk_sys);
		wdog_vector_ack <= 1'b0;
		wdog_restart <= 1'b0;
		#1;
	endtask
endmodule

// >>> test/tb.sv
// Self-checking testbench for the watchdog, supply monitor and reset cause block
`timescale 1ns/1ps
module tb;
	logic       clk_sys = 1'b0;
	logic       rst_n;
	logic       dev_reset;
	logic       wdog_always_on_fuse;
	logic       pin_reset_n;
	logic       supply_below_level;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic       io_we;
	logic       io_re;
	logic [7:0] io_rdata;
	logic       change_protect_we;
	logic [7:0] change_protect_wdata;
	logic       wdog_restart;
	logic       wdog_vector_ack;
	logic       wdog_irq_req;
	logic       wdog_reset_pulse;
	logic       supply_low_irq;
	logic       supply_por_req;
	logic       last_pulse = 1'b0;
	int         mismatches = 0;
	int         comparisons = 0;
	int         rst_pulses = 0;
	int         long_pulse = 0;
	int         sup_irqs = 0;
	int         n;

	wsm_top #(.TICK_DIV(1)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .dev_reset(dev_reset),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
		.io_rdata(io_rdata), .change_protect_we(change_protect_we),
		.change_protect_wdata(change_protect_wdata), .wdog_restart(wdog_restart),
		.wdog_vector_ack(wdog_vector_ack), .wdog_always_on_fuse(wdog_always_on_fuse),
		.pin_reset_n(pin_reset_n), .supply_below_level(supply_below_level),
		.wdog_irq_req(wdog_irq_req), .wdog_reset_pulse(wdog_reset_pulse),
		.supply_low_irq(supply_low_irq), .supply_por_req(supply_por_req));

	wsm_core_model core_u (.clk_sys(clk_sys), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
		.change_protect_we(change_protect_we), .change_protect_wdata(change_protect_wdata),
		.wdog_restart(wdog_restart), .wdog_vector_ack(wdog_vector_ack));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	// Count reset pulses, pulses longer than a cycle and supply interrupts
	always @(posedge clk_sys)
	begin
		if (wdog_reset_pulse === 1'b1)
			rst_pulses++;
		if (wdog_reset_pulse === 1'b1 && last_pulse === 1'b1)
			long_pulse++;
		last_pulse = wdog_reset_pulse;
		if (supply_low_irq === 1'b1)
			sup_irqs++;
	end

	// Compare and report at once
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read a register and compare
	task automatic rc(input logic [5:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		core_u.rd(a, d);
		chk(nm, e, d);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// Bounded wait: sel 0 waits for the interrupt request, 1 for the reset pulse
	task automatic wait_evt(input bit sel, input int lim, output int k);
		k = 0;
		while (k < lim && (sel ? wdog_reset_pulse : wdog_irq_req) !== 1'b1)
		begin
			@(posedge clk_sys);
			#1;
			k++;
		end
	endtask

	// Power-on reset held four cycles
	task automatic pwr_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(1);
	endtask

	// Device reset as the chip reset controller would apply it
	task automatic dev_rst();
		@(posedge clk_sys);
		dev_reset <= 1'b1;
		@(posedge clk_sys);
		dev_reset <= 1'b0;
		#1;
	endtask

	// Clear the cause flags and stop the watchdog through the protected sequence
	task automatic stop_wdog();
		core_u.wr(6'h3B, 8'h00);
		core_u.unlock();
		core_u.wr(6'h31, 8'h00);
	endtask

	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, well past the longest expected run
	initial
	begin
		#600000;
		mismatches++;
		end_of_test();
	end

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		dev_reset = 1'b0;
		wdog_always_on_fuse = 1'b1;
		pin_reset_n = 1'b1;
		supply_below_level = 1'b0;
		pwr_reset();
		rc(6'h31, 8'h00, "wdog_reset_val");
		rc(6'h34, 8'h00, "supply_reset_val");
		rc(6'h3B, 8'h01, "cause_reset_val");
		rc(6'h20, 8'h00, "unmapped");
		core_u.wr(6'h31, 8'hFF);
		rc(6'h31, 8'h69, "wdog_rsv_bit");
		core_u.wr(6'h31, 8'h00);
		rc(6'h31, 8'h08, "rsten_unprotected");
		stop_wdog();
		rc(6'h31, 8'h00, "rsten_protected");
		rc(6'h3B, 8'h00, "cause_cleared");
		// Interrupt mode, period for codes 0..2, both ways of clearing the flag
		for (int c = 0; c < 3; c++)
		begin
			core_u.wr(6'h31, 8'hC0 | 8'(c));
			core_u.strobe(1'b0);
			wait_evt(1'b0, 9000, n);
			chk("period", 8'h01, 8'(n >= (2048 << c) - 2 && n <= (2048 << c) + 3));
			rc(6'h31, 8'hC0 | 8'(c), "flag_set");
			if (c == 0)
				core_u.strobe(1'b1);
			else
				core_u.wr(6'h31, 8'hC0 | 8'(c));
			rc(6'h31, 8'h40 | 8'(c), "flag_clear");
		end
		chk("irq_mode_no_reset", 8'h00, 8'(rst_pulses));
		// Combined mode: vector drops to reset mode, unserviced second expiry resets
		core_u.wr(6'h31, 8'h48);
		core_u.strobe(1'b0);
		wait_evt(1'b0, 2100, n);
		rc(6'h31, 8'hC8, "combined_flag");
		core_u.strobe(1'b1);
		rc(6'h31, 8'h08, "combined_vector");
		core_u.wr(6'h31, 8'h48);
		core_u.strobe(1'b0);
		wait_evt(1'b0, 2100, n);
		wait_evt(1'b1, 2100, n);
		chk("second_expiry", 8'h01, 8'(n < 2100));
		cyc(2);
		chk("pulse_count", 8'h01, 8'(rst_pulses));
		chk("pulse_len", 8'h00, 8'(long_pulse));
		dev_rst();
		rc(6'h3B, 8'h08, "wdog_cause");
		rc(6'h31, 8'h08, "rsten_forced");
		core_u.unlock();
		core_u.wr(6'h31, 8'h00);
		rc(6'h31, 8'h08, "rsten_held");
		stop_wdog();
		rc(6'h31, 8'h00, "rsten_released");
		// Programmed fuse resets on expiry with both enables clear
		@(posedge clk_sys);
		wdog_always_on_fuse <= 1'b0;
		core_u.strobe(1'b0);
		rc(6'h31, 8'h08, "fuse_rsten");
		// Period change without the unlock must not land while the fuse is programmed
		core_u.wr(6'h31, 8'h01);
		rc(6'h31, 8'h08, "fuse_period_locked");
		wait_evt(1'b1, 2100, n);
		chk("fuse_reset", 8'h01, 8'(n < 2100));
		@(posedge clk_sys);
		wdog_always_on_fuse <= 1'b1;
		dev_rst();
		stop_wdog();
		// External pin reset sets only its own cause flag
		@(posedge clk_sys);
		pin_reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		pin_reset_n <= 1'b1;
		cyc(4);
		rc(6'h3B, 8'h02, "pin_cause");
		core_u.wr(6'h3B, 8'hFF);
		rc(6'h3B, 8'h0B, "cause_rsv_bits");
		stop_wdog();
		// Every trip selection with the supply below its level
		@(posedge clk_sys);
		supply_below_level <= 1'b1;
		for (int t = 0; t < 8; t++)
		begin
			core_u.wr(6'h34, 8'(t));
			cyc(6);
			rc(6'h34, ((t == 3 || t == 4) ? 8'h80 : 8'h00) | 8'(t), "trip_flag");
			chk("trip_por", 8'(t == 1 || t == 2), 8'(supply_por_req));
		end
		// Supply interrupt on each rise of the flag; flag is read-only
		core_u.wr(6'h34, 8'h00);
		sup_irqs = 0;
		core_u.wr(6'h34, 8'h43);
		cyc(6);
		chk("supply_irq", 8'h01, 8'(sup_irqs));
		core_u.wr(6'h34, 8'h7B);
		rc(6'h34, 8'hC3, "supply_ro");
		@(posedge clk_sys);
		supply_below_level <= 1'b0;
		cyc(6);
		rc(6'h34, 8'h43, "supply_rise");
		@(posedge clk_sys);
		supply_below_level <= 1'b1;
		cyc(6);
		chk("supply_irq_again", 8'h02, 8'(sup_irqs));
		pwr_reset();
		rc(6'h3B, 8'h01, "power_cause");
		end_of_test();
	end
endmodule
